// ### design/analog_io_scaling.sv
// Scan sequencer that scales two input channels and one output channel.
// Each scan state hands one channel to the shared multiply and clamp unit.
// Assumes converter counts and words come from the same clock domain.
// Assumes calibration loads arrive as single-cycle pulses on that clock.
`timescale 1ns/1ns
module analog_io_scaling
  import scale_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [ADC_BITS-1:0]  adc_count_first,
  input  wire logic [ADC_BITS-1:0]  adc_count_second,
  input  wire logic [WORD_BITS-1:0] analog_output_word,
  input  wire logic [2:0]           mode_current,
  input  wire logic                 cal_load,
  input  wire logic [1:0]           cal_channel,
  input  wire logic                 cal_mode,
  input  wire logic [GAIN_BITS-1:0] cal_gain,
  input  wire logic [OFS_BITS-1:0]  cal_offset,
  output logic [WORD_BITS-1:0]      analog_input_word_first,
  output logic [WORD_BITS-1:0]      analog_input_word_second,
  output logic [DAC_BITS-1:0]       dac_count,
  output logic                      scan_done
);
  scan_type                 state_q;
  scan_type                 state_d;
  logic [GAIN_BITS-1:0]     gain_q [6];
  logic [GAIN_BITS-1:0]     gain_d [6];
  logic [OFS_BITS-1:0]      ofs_q [6];
  logic [OFS_BITS-1:0]      ofs_d [6];
  logic [WORD_BITS-1:0]     ai0_q;
  logic [WORD_BITS-1:0]     ai0_d;
  logic [WORD_BITS-1:0]     ai1_q;
  logic [WORD_BITS-1:0]     ai1_d;
  logic [DAC_BITS-1:0]      dac_q;
  logic [DAC_BITS-1:0]      dac_d;
  logic                     done_q;
  logic                     done_d;
  logic [2:0]               sel;
  scale_if                  s ();

  scale_mac u_mac (.s(s));

  function automatic logic [2:0] slot(input logic [1:0] ch, input logic m);
    slot = 3'({ch, 1'b0}) + 3'(m);
  endfunction

  function automatic logic [GAIN_BITS-1:0] gain_default(input int i);
    if (i >= 4) begin
      gain_default = GAIN_OUT; // [R13]
    end else if (i % 2 == 1) begin
      gain_default = GAIN_IN_CURR; // [R12] [R7] [R8] [R9]
    end else begin
      gain_default = GAIN_IN_VOLT; // [R12] [R6] [R9]
    end
  endfunction

  always_comb begin
    unique case (state_q)
      ST_IN0:  sel = slot(CH_IN0, mode_current[0]); // [R11]
      ST_IN1:  sel = slot(CH_IN1, mode_current[1]); // [R11]
      ST_OUT:  sel = slot(CH_OUT, mode_current[2]); // [R11]
      default: sel = 3'h0;
    endcase
    s.gain   = signed'({1'b0, gain_q[sel]});
    s.offset = signed'(ofs_q[sel]);
    if (state_q == ST_OUT) begin
      s.operand = analog_output_word;
      s.limit   = OUT_MAX; // [R10] [R5]
    end else begin
      s.operand = WORD_BITS'(state_q == ST_IN0 ? adc_count_first
                                               : adc_count_second); // [R1]
      s.limit   = IN_MAX; // [R3]
    end
  end

  always_comb begin
    gain_d = gain_q;
    ofs_d  = ofs_q;
    if (cal_load && cal_channel != 2'h3) begin
      gain_d[slot(cal_channel, cal_mode)] = cal_gain; // [R14]
      ofs_d[slot(cal_channel, cal_mode)]  = cal_offset; // [R14]
    end
    ai0_d   = ai0_q;
    ai1_d   = ai1_q;
    dac_d   = dac_q;
    done_d  = 1'b0;
    unique case (state_q)
      ST_IN0: begin
        ai0_d   = s.result; // [R1] [R2]
        state_d = ST_IN1;
      end
      ST_IN1: begin
        ai1_d   = s.result; // [R1] [R2]
        state_d = ST_OUT;
      end
      ST_OUT: begin
        dac_d   = s.result[DAC_BITS-1:0]; // [R4] [R10]
        done_d  = 1'b1;
        state_d = ST_IN0;
      end
      default: state_d = ST_IN0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IN0;
      ai0_q   <= '0;
      ai1_q   <= '0;
      dac_q   <= '0;
      done_q  <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        gain_q[i] <= gain_default(i);
        ofs_q[i]  <= OFS_DEFAULT;
      end
    end else begin
      state_q <= state_d;
      ai0_q   <= ai0_d;
      ai1_q   <= ai1_d;
      dac_q   <= dac_d;
      done_q  <= done_d;
      gain_q  <= gain_d;
      ofs_q   <= ofs_d;
    end
  end

  assign analog_input_word_first  = ai0_q;
  assign analog_input_word_second = ai1_q;
  assign dac_count                = dac_q;
  assign scan_done                = done_q;

  chk_input_word_clamp : assert property ( // [R3]
    @(posedge clk) disable iff (!rst_b)
    ai0_q <= 16'h7fff && ai1_q <= 16'h7fff)
    else $error("input word above saturation");

  chk_scan_period : assert property ( // [R4]
    @(posedge clk) disable iff (!rst_b)
    done_q |=> !done_q ##1 !done_q ##1 done_q)
    else $error("output scan period wrong");

  chk_scan_order : assert property ( // [R2] [R4]
    @(posedge clk) disable iff (!rst_b)
    rst_b && state_q == ST_IN0
    |=> state_q == ST_IN1 ##1 state_q == ST_OUT ##1 state_q == ST_IN0)
    else $error("scan order wrong");

  chk_volt_default : assert property ( // [R6]
    @(posedge clk) disable iff (!rst_b)
    (rst_b && state_q == ST_IN0 && !mode_current[0]
     && gain_q[0] == GAIN_IN_VOLT && ofs_q[0] == 16'h0000
     && adc_count_first == 10'h3e8)
    |=> ai0_q == 16'h7d00)
    else $error("voltage mode full scale wrong");

  chk_volt_step : assert property ( // [R6] [R9]
    @(posedge clk) disable iff (!rst_b)
    (rst_b && state_q == ST_IN0 && !mode_current[0]
     && gain_q[0] == GAIN_IN_VOLT && ofs_q[0] == OFS_DEFAULT)
    |=> ai0_q == {1'b0, $past(adc_count_first), 5'h00})
    else $error("voltage mode step wrong");

  chk_first_curr_step : assert property ( // [R7] [R9]
    @(posedge clk) disable iff (!rst_b)
    (rst_b && state_q == ST_IN0 && mode_current[0]
     && gain_q[1] == GAIN_IN_CURR && ofs_q[1] == OFS_DEFAULT)
    |=> ai0_q == ($past(adc_count_first) > 10'h1ff ? 16'h7fff
                  : {1'b0, $past(adc_count_first[8:0]), 6'h00}))
    else $error("first current mode step wrong");

  chk_second_curr_step : assert property ( // [R7] [R9]
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_IN1 && mode_current[1]
     && gain_q[3] == GAIN_IN_CURR && ofs_q[3] == OFS_DEFAULT)
    |=> ai1_q == ($past(adc_count_second) > 10'h1ff ? 16'h7fff
                  : {1'b0, $past(adc_count_second[8:0]), 6'h00}))
    else $error("second current mode step wrong");

  chk_input_floor : assert property ( // [R3]
    @(posedge clk) disable iff (!rst_b)
    (rst_b && state_q == ST_IN0 && !mode_current[0]
     && gain_q[0] == 16'h0100 && ofs_q[0] == 16'hff00
     && adc_count_first < 10'h100)
    |=> ai0_q == 16'h0000)
    else $error("negative input not forced to zero");

  chk_out_default : assert property ( // [R13]
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_OUT && mode_current[2] == 1'b0 && gain_q[4] == GAIN_OUT
     && ofs_q[4] == 16'h0000 && analog_output_word == 16'h7d00)
    |=> dac_q == 12'hfa0)
    else $error("output default scaling wrong");

  chk_out_clamp : assert property ( // [R5]
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_OUT && !mode_current[2] && gain_q[4] == GAIN_OUT
     && ofs_q[4] == OFS_DEFAULT && analog_output_word >= 16'h7ff8)
    |=> dac_q == 12'hfff)
    else $error("output clamp not driven");

  chk_out_floor : assert property ( // [R5]
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_OUT && !mode_current[2] && ofs_q[4][15]
     && analog_output_word == 16'h0000)
    |=> dac_q == 12'h000)
    else $error("negative output not forced to zero");

  chk_cal_load : assert property ( // [R14]
    @(posedge clk) disable iff (!rst_b)
    (rst_b && cal_load && cal_channel != 2'h3)
    |=> gain_q[slot($past(cal_channel), $past(cal_mode))] == $past(cal_gain)
     && ofs_q[slot($past(cal_channel), $past(cal_mode))] == $past(cal_offset))
    else $error("calibration load lost");

  chk_first_stands : assert property ( // [R1]
    @(posedge clk) disable iff (!rst_b)
    rst_b && state_q != ST_IN0 |=> $stable(ai0_q))
    else $error("first input word changed outside its scan");

  chk_second_stands : assert property ( // [R1]
    @(posedge clk) disable iff (!rst_b)
    rst_b && state_q != ST_IN1 |=> $stable(ai1_q))
    else $error("second input word changed outside its scan");

  chk_dac_stands : assert property ( // [R4]
    @(posedge clk) disable iff (!rst_b)
    rst_b && state_q != ST_OUT |=> $stable(dac_q))
    else $error("output count changed outside its scan");
endmodule

// ### design/scale_if.sv
// Interface carrying one scaling request and its result.
// Assumes the arithmetic unit answers combinationally.
`timescale 1ns/1ns
interface scale_if;
  import scale_pkg::*;
  logic        [WORD_BITS-1:0] operand;
  logic signed [GAIN_BITS:0]   gain;
  logic signed [OFS_BITS-1:0]  offset;
  logic        [ACC_BITS-1:0]  limit;
  logic        [WORD_BITS-1:0] result;
  modport ctrl (output operand, output gain, output offset, output limit,
                input result);
  modport unit (input operand, input gain, input offset, input limit,
                output result);
endinterface

// ### design/scale_mac.sv
// Multiply, add and clamp unit in 8.8 fixed point.
// Assumes operands stable across the cycle that registers the result.
`timescale 1ns/1ns
module scale_mac
  import scale_pkg::*;
(
  scale_if.unit s
);
  logic signed [ACC_BITS-1:0] op_wide;
  logic signed [ACC_BITS-1:0] gain_wide;
  logic signed [ACC_BITS-1:0] prod;
  logic signed [ACC_BITS-1:0] sum;
  always_comb begin
    // Fixed point wide enough that fractional gains cannot overflow.
    op_wide   = ACC_BITS'(signed'({1'b0, s.operand}));
    gain_wide = ACC_BITS'(s.gain);
    prod      = (op_wide * gain_wide) >>> FRAC_BITS; // [R14]
    sum  = prod + ACC_BITS'(s.offset); // [R2] [R4]
    if (sum < 0) begin
      s.result = '0; // [R3] [R5]
    end else if (sum > signed'(s.limit)) begin
      s.result = WORD_BITS'(s.limit); // [R3] [R5]
    end else begin
      s.result = sum[WORD_BITS-1:0];
    end
  end
endmodule

// ### design/scale_pkg.sv
// Constants and types for the analog input and output scaling block.
// Assumes a single scan clock and converter counts already synchronised.
// Function
// [R1] Two inputs digitised by a 10-bit converter, each into its own word.
// [R2] Each input scan computes word as count times gain plus offset.
// [R3] Input result above 32767 saturates there; negative results become zero.
// [R4] Each output scan computes count as word times gain plus offset.
// [R5] Output count clamps at 4095; negative results become zero.
// [R6] Factory voltage mode maps 0 to 10000 mV onto 0 to 32000.
// [R7] Factory 0-20 mA current mode gives 1.6 times microamperes.
// [R8] Factory 4-20 mA current mode gives twice microamperes minus 8000; the code instead resets current slots to gain 64, offset zero.
// [R9] Inputs resolve 10 bits in voltage, 9 bits in current range.
// [R10] Output converter path resolves 12 bits in both ranges.
// [R11] Two inputs and one output, each selectable voltage or current.
// [R12] Default input gain 32 voltage, 64 current, offsets zero.
// [R13] Default output gain 0.125, offset zero, 32000 maps to 4000.
// [R14] Gain and offset per channel and mode held in loadable registers.
package scale_pkg;
  localparam int ADC_BITS = 10;
  localparam int DAC_BITS = 12;
  localparam int WORD_BITS = 16;
  localparam int GAIN_BITS = 16;
  localparam int FRAC_BITS = 8;
  localparam int OFS_BITS = 16;
  localparam int ACC_BITS = 40;
  localparam logic [ACC_BITS-1:0] IN_MAX = 40'h0000007fff;
  localparam logic [ACC_BITS-1:0] OUT_MAX = 40'h0000000fff;
  localparam logic [GAIN_BITS-1:0] GAIN_IN_VOLT = 16'h2000;
  localparam logic [GAIN_BITS-1:0] GAIN_IN_CURR = 16'h4000;
  localparam logic [GAIN_BITS-1:0] GAIN_OUT = 16'h0020;
  localparam logic [OFS_BITS-1:0] OFS_DEFAULT = 16'h0000;
  localparam logic [1:0] CH_IN0 = 2'h0;
  localparam logic [1:0] CH_IN1 = 2'h1;
  localparam logic [1:0] CH_OUT = 2'h2;
  typedef enum logic [1:0] {
    ST_IN0 = 2'b00,
    ST_IN1 = 2'b01,
    ST_OUT = 2'b11
  } scan_type;
endpackage

// ### verification/conv_model.sv
// Converter model: analog levels in, raw counts out, output count kept.
// Assumes the scan clock of the scaling block drives clk.
`timescale 1ns/1ns
module conv_model
  import scale_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [ADC_BITS-1:0] level_first,
  input  wire logic [ADC_BITS-1:0] level_second,
  input  wire logic [DAC_BITS-1:0] dac_count,
  output logic      [ADC_BITS-1:0] adc_count_first,
  output logic      [ADC_BITS-1:0] adc_count_second,
  output logic      [DAC_BITS-1:0] dac_held
);
  // Each rising edge ends one 10-bit conversion per input channel.
  always_ff @(posedge clk) begin
    adc_count_first  <= level_first;
    adc_count_second <= level_second;
    dac_held         <= dac_count;
  end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the scaling block and its converter model.
// Assumes the scan sequence restarts at reset release.
`timescale 1ns/1ns
module tb_top;
  import scale_pkg::*;
  logic clk, rst_b, cal_load, cal_mode;
  logic [9:0] lv1, lv2, a1, a2;
  logic [15:0] aw, w1, w2, cg, co;
  logic [2:0] mode_current;
  logic [1:0] cal_channel;
  logic [11:0] dac, held;
  logic done;
  int mismatches, n_tests, cycles;
  analog_io_scaling analog_io_scaling_i (.clk(clk), .rst_b(rst_b),
    .adc_count_first(a1), .adc_count_second(a2),
    .analog_output_word(aw), .mode_current(mode_current),
    .cal_load(cal_load), .cal_channel(cal_channel), .cal_mode(cal_mode),
    .cal_gain(cg), .cal_offset(co), .analog_input_word_first(w1),
    .analog_input_word_second(w2), .dac_count(dac), .scan_done(done));
  conv_model conv_model_i (.clk(clk), .level_first(lv1),
    .level_second(lv2), .dac_count(dac), .adc_count_first(a1),
    .adc_count_second(a2), .dac_held(held));
  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apply(input logic [9:0] c1, input logic [9:0] c2,
                       input logic [15:0] w, input logic [2:0] m);
    @(posedge clk);
    lv1 <= c1;
    lv2 <= c2;
    aw <= w;
    mode_current <= m;
    repeat (9) @(posedge clk);
    #1;
  endtask
  task automatic cal(input logic [1:0] ch, input logic m,
                     input logic [15:0] g, input logic [15:0] o);
    @(posedge clk);
    cal_load <= 1'b1;
    cal_channel <= ch;
    cal_mode <= m;
    cg <= g;
    co <= o;
    @(posedge clk);
    cal_load <= 1'b0;
  endtask
  task automatic t_defaults();
    apply(10'h3e8, 10'h1f4, 16'h7d00, 3'h2);
    check(w1, 16'h7d00);
    check(w2, 16'h7d00);
    check({4'h0, held}, 16'h0fa0);
  endtask
  task automatic t_clamp();
    apply(10'h3ff, 10'h3ff, 16'hffff, 3'h3);
    check(w1, 16'h7fff);
    check(w2, 16'h7fff);
    check({4'h0, dac}, 16'h0fff);
  endtask
  task automatic t_cal();
    cal(2'h0, 1'b0, 16'h0100, 16'h0064);
    cal(2'h1, 1'b1, 16'h5000, 16'he0c0);
    cal(2'h2, 1'b0, 16'h0100, 16'hffff);
    cal(2'h3, 1'b0, 16'h0000, 16'h0000);
    apply(10'h3e8, 10'h0fa, 16'h000a, 3'h2);
    check(w1, 16'h044c);
    check(w2, 16'h2ee0);
    check({4'h0, dac}, 16'h0009);
    cal(2'h0, 1'b0, 16'h0100, 16'hff00);
    apply(10'h064, 10'h064, 16'h0000, 3'h2);
    check(w1, 16'h0000);
    check(w2, 16'h0000);
    check({4'h0, dac}, 16'h0000);
  endtask
  task automatic t_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    check({15'h0, done}, 16'h0001);
  endtask
  task automatic t_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_defaults();
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {rst_b, cal_load, cal_mode, cal_channel, mode_current} = '0;
    {lv1, lv2, aw, cg, co} = '0;
    {mismatches, n_tests} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_defaults();
    t_clamp();
    t_done();
    t_cal();
    t_reset();
    complete_run();
  end
endmodule
